// *** bench/config_serial_port_props.sv ***
`timescale 1ns/1ps
module config_serial_port_props (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_port_transfer_clock,
  input wire logic       i_port_access_enable_n,
  input wire logic       o_port_serial_out,
  input wire logic       o_port_serial_out_oe,
  input wire logic       o_service_request_n,
  input wire logic       o_service_request_oe,
  input wire logic [6:0] i_supply_status,
  input wire logic [6:0] o_read_addr,
  input wire logic       o_write_valid,
  input wire logic       i_write_ready,
  input wire logic [6:0] o_write_addr,
  input wire logic [7:0] o_write_data
);
  // ====
  // Pin history, so that output moves can be tied to a cause
  logic [4:0] lk;
  logic [7:0] en;
  always_ff @(posedge i_clk) begin
    lk <= {lk[3:0], i_port_transfer_clock};
    en <= {en[6:0], i_port_access_enable_n};
  end
  wire rose = |(lk[3:1] & ~lk[4:2]);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence idle6;
    i_port_access_enable_n [*6];
  endsequence
  chk_idle_quiet: assert property (idle6 |-> !o_port_serial_out_oe)
    else $error("serial output driven while idle");
  chk_addr_idle: assert property (idle6 |-> $stable(o_read_addr))
    else $error("address moved while idle");
  chk_data_low: assert property (!o_port_serial_out)
    else $error("serial output level not low");
  chk_req_low: assert property (!o_service_request_n)
    else $error("request level not low");
  chk_oe_edge: assert property ($changed(o_port_serial_out_oe) |-> rose || |en[4:1])
    else $error("serial output moved without a link rise");
  chk_fifo_hold: assert property (o_write_valid && !i_write_ready |=>
    o_write_valid && $stable(o_write_addr) && $stable(o_write_data))
    else $error("stalled write head changed");
  chk_req_set: assert property (|i_supply_status |-> ##[1:2] o_service_request_oe)
    else $error("status event raised no request");
  chk_req_clear: assert property ($fell(o_service_request_oe) |-> !(&en))
    else $error("request released outside an access");
  chk_write_cause: assert property ($rose(o_write_valid) |-> !(&en))
    else $error("write appeared without an access");
endmodule
bind config_serial_port config_serial_port_props chk (.*);

// *** bench/port_primary_model.sv ***
`timescale 1ns/1ps
module port_primary_model (
  output logic      o_clk,
  output logic      o_en_n,
  output logic      o_si,
  input  wire logic i_so
);
  // ====
  // Link clock rests low between frames; half period 400 ns
  initial begin
    o_clk = 1'b0;
    o_en_n = 1'b1;
    o_si = 1'b0;
  end
  task automatic open_access();
    #400 o_en_n = 1'b0;
  endtask
  // Released data line flips so a stale bit is never mistaken for live data
  task automatic close_access();
    #400 o_en_n = 1'b1;
    o_si = ~o_si;
    #1200;
  endtask
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      #200 o_si = tx[i];
      #200 o_clk = 1'b1;
      #400 rx = {rx[6:0], i_so};
      o_clk = 1'b0;
    end
  endtask
endmodule

// *** bench/serial_config_port_secondary_test.sv ***
`timescale 1ns/1ps
module serial_config_port_secondary_test;
  import config_port_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        lk, en_n, si, so, so_oe, rq_n, rq_oe, wr_valid;
  logic        wr_ready = 1'b0;
  logic [6:0]  supply = 7'h00;
  logic [6:0]  rd_addr, wr_addr, a;
  logic [7:0]  rd_data, wr_data, rx;
  logic [14:0] q[$];
  int          err_total = 0;
  int          comparisons = 0;
  always #50 clk = ~clk;
  function automatic logic [7:0] rd_fn(input logic [6:0] x);
    return {x[2:0], ~x[6:2]};
  endfunction
  assign rd_data = rd_fn(rd_addr);
  port_primary_model pm (.o_clk(lk), .o_en_n(en_n), .o_si(si), .i_so(so_oe ? so : 1'b1));
  config_serial_port dut (
    .i_clk(clk), .i_reset(reset), .i_port_transfer_clock(lk), .i_port_access_enable_n(en_n),
    .i_port_serial_in(si), .o_port_serial_out(so), .o_port_serial_out_oe(so_oe),
    .o_service_request_n(rq_n), .o_service_request_oe(rq_oe), .i_supply_status(supply),
    .o_read_addr(rd_addr), .i_read_data(rd_data), .o_write_valid(wr_valid),
    .i_write_ready(wr_ready), .o_write_addr(wr_addr), .o_write_data(wr_data));
  // ====
  // Checking and closing
  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [14:0] got, input logic [14:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ====
  // Accesses
  task automatic wr(input logic [6:0] ad, input int n);
    logic [7:0] d;
    pm.open_access();
    pm.shift({1'b0, ad}, 8, rx);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      pm.shift(d, 8, rx);
      if (q.size() < FIFO_DEPTH) q.push_back({ad + 7'(i), d});
    end
    pm.close_access();
  endtask
  task automatic rd(input logic [6:0] ad, input logic [7:0] e[3]);
    pm.open_access();
    pm.shift({1'b1, ad}, 8, rx);
    for (int i = 0; i < 3; i++) begin
      pm.shift(8'h00, 8, rx);
      chk_val({7'h00, rx}, {7'h00, e[i]});
    end
    pm.close_access();
  endtask
  // Far side stalls until the bench pops one entry at a time
  task automatic drain();
    logic [14:0] e;
    @(posedge clk);
    #1;
    while (q.size() > 0) begin
      e = q.pop_front();
      for (int k = 0; k < 40 && wr_valid !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      chk_val({wr_addr, wr_data}, e);
      wr_ready = 1'b1;
      @(posedge clk);
      #1 wr_ready = 1'b0;
    end
    chk_flag(wr_valid, 1'b0);
  endtask
  initial begin
    #3000000;
    err_total++;
    summarize();
  end
  initial begin
    void'($urandom(46));
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk_flag(so_oe, 1'b0);
    chk_flag(rq_oe, 1'b0);
    chk_val({8'h00, rd_addr}, 15'h0000);
    wr(7'h7C, 9);
    chk_flag(rq_oe, 1'b1);
    a = 7'($urandom_range(1, 127));
    @(posedge clk);
    #1 supply = a;
    @(posedge clk);
    #1 supply = 7'h00;
    rd(7'h00, '{{1'b1, a}, 8'h80, rd_fn(7'h02)});
    chk_flag(rq_oe, 1'b0);
    drain();
    pm.open_access();
    pm.shift(8'h03, 8, rx);
    pm.shift(8'hC3, 5, rx);
    pm.close_access();
    pm.open_access();
    pm.shift(8'h82, 8, rx);
    pm.shift(8'h00, 3, rx);
    pm.close_access();
    chk_flag(wr_valid, 1'b0);
    chk_flag(so_oe, 1'b0);
    repeat (3) begin
      a = 7'($urandom_range(2, 125));
      wr(a, 2);
      drain();
      rd(a, '{rd_fn(a), rd_fn(a + 7'h01), rd_fn(a + 7'h02)});
    end
    summarize();
  end
endmodule

// *** rtl/byte_fifo.sv ***
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_type;

  fifo_state_type fifo;
  fifo_state_type next_fifo;
  logic           push;
  logic           pop;

  assign o_in_ready  = (fifo.count != (AW+1)'(DEPTH));
  assign o_out_valid = (fifo.count != '0);
  assign o_out_data  = fifo.mem[fifo.rd_ptr];

  always_comb begin
    next_fifo = fifo;
    push      = i_in_valid && o_in_ready;
    pop       = o_out_valid && i_out_ready;
    if (push) begin
      next_fifo.mem[fifo.wr_ptr] = i_in_data;
      next_fifo.wr_ptr = (fifo.wr_ptr == AW'(DEPTH-1)) ? '0 : fifo.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_fifo.rd_ptr = (fifo.rd_ptr == AW'(DEPTH-1)) ? '0 : fifo.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_fifo.count = fifo.count + 1'b1;
    end else if (pop && !push) begin
      next_fifo.count = fifo.count - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fifo <= '0;
    end else begin
      fifo <= next_fifo;
    end
  end

endmodule

// *** rtl/config_port_pkg.sv ***
package config_port_pkg;

  // ==========================================================================
  // Framing
  localparam int          BYTE_BITS      = 8;
  localparam int          ADDR_WIDTH     = 7;
  localparam int          READ_FLAG_BIT  = 7;
  localparam int          STATUS_WIDTH   = 7;
  localparam int          OVERRUN_BIT    = 7;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          FIFO_WIDTH     = ADDR_WIDTH + BYTE_BITS;

  // ==========================================================================
  // Addresses of the block's own status bytes
  localparam logic [6:0]  ADDR_LATCHED   = 7'h00;
  localparam logic [6:0]  ADDR_LIVE      = 7'h01;

  // ==========================================================================
  // Reset values and the last bit count
  localparam logic [2:0]  BIT_COUNT_RESET = 3'h0;
  localparam logic [2:0]  BIT_COUNT_LAST  = 3'h7;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  localparam logic [6:0]  ADDR_RESET      = 7'h00;

  typedef enum logic [1:0] {
    st_idle,
    st_command,
    st_write,
    st_read
  } port_phase_type;

endpackage

// *** rtl/config_serial_port.sv ***
`timescale 1ns/1ps
module config_serial_port (
  input  wire logic                                  i_clk,
  input  wire logic                                  i_reset,
  input  wire logic                                  i_port_transfer_clock,
  input  wire logic                                  i_port_access_enable_n,
  input  wire logic                                  i_port_serial_in,
  output logic                                       o_port_serial_out,
  output logic                                       o_port_serial_out_oe,
  output logic                                       o_service_request_n,
  output logic                                       o_service_request_oe,
  input  wire logic [config_port_pkg::STATUS_WIDTH-1:0] i_supply_status,
  output logic [config_port_pkg::ADDR_WIDTH-1:0]     o_read_addr,
  input  wire logic [config_port_pkg::BYTE_BITS-1:0] i_read_data,
  output logic                                       o_write_valid,
  input  wire logic                                  i_write_ready,
  output logic [config_port_pkg::ADDR_WIDTH-1:0]     o_write_addr,
  output logic [config_port_pkg::BYTE_BITS-1:0]      o_write_data
);
  import config_port_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [2:0]     clk_sync;
    logic [1:0]     en_sync;
    logic [1:0]     din_sync;
    port_phase_type phase;
    logic [2:0]     bit_count;
    logic [7:0]     rx_shift;
    logic [7:0]     tx_shift;
    logic           out_oe;
    logic [6:0]     address;
    logic [7:0]     latched;
    logic           load_pending;
  } port_state_type;

  port_state_type port;
  port_state_type next_port;

  logic                  clk_rise;
  logic                  clk_fall;
  logic                  enable_low;
  logic [7:0]            rx_byte;
  logic                  byte_done;
  logic                  push_valid;
  logic                  push_ready;
  logic [FIFO_WIDTH-1:0] push_data;
  logic [FIFO_WIDTH-1:0] pop_data;
  logic [7:0]            events;

  // ==========================================================================
  // Edge detection on the synchronised link clock
  assign clk_rise   = port.clk_sync[1] && !port.clk_sync[2];
  assign clk_fall   = !port.clk_sync[1] && port.clk_sync[2];
  assign enable_low = !port.en_sync[1];
  assign rx_byte    = {port.rx_shift[6:0], port.din_sync[1]};
  assign byte_done  = clk_fall && (port.bit_count == BIT_COUNT_LAST);

  // Only data bytes of a write phase enter the stream
  assign push_valid = byte_done && (port.phase == st_write) && enable_low;
  assign push_data  = {port.address, rx_byte};

  // Hardware status events; an overrun is a lost byte at a full FIFO
  assign events = {push_valid && !push_ready, i_supply_status};

  // ==========================================================================
  // Read source: own status bytes, else the user side
  function automatic logic [7:0] read_value(input logic [6:0] addr, input logic [7:0] latched);
    logic [7:0] value;
    value = i_read_data;
    if (addr == ADDR_LATCHED) begin
      value = latched;
    end else if (addr == ADDR_LIVE) begin
      value = {!push_ready, i_supply_status};
    end
    return value;
  endfunction

  always_comb begin
    next_port = port;
    next_port.clk_sync = {port.clk_sync[1:0], i_port_transfer_clock};
    next_port.en_sync  = {port.en_sync[0], i_port_access_enable_n};
    next_port.din_sync = {port.din_sync[0], i_port_serial_in};
    // Set wins over clear, so an event in the clearing cycle survives
    next_port.latched  = port.latched | events;

    if (!enable_low) begin
      // Abort or end of access; any partial byte is thrown away
      next_port.phase     = st_idle;
      next_port.bit_count = BIT_COUNT_RESET;
      next_port.out_oe    = 1'b0;
      next_port.load_pending = 1'b0;
    end else begin
      if (port.phase == st_idle) begin
        next_port.phase     = st_command;
        next_port.bit_count = BIT_COUNT_RESET;
        next_port.tx_shift  = BYTE_RESET;
      end
      // No timeout anywhere: the link may stall between edges forever
      if (clk_fall && port.phase != st_idle) begin
        next_port.rx_shift  = rx_byte;
        next_port.bit_count = port.bit_count + 1'b1;
      end
      if (clk_rise && port.phase == st_read) begin
        // Open drain: enable pulls low for a zero, releases for a one
        next_port.out_oe   = !port.tx_shift[7];
        next_port.tx_shift = {port.tx_shift[6:0], 1'b0};
      end
      // Read data are taken a cycle after the address moves, once o_read_addr shows it
      if (port.load_pending) begin
        next_port.load_pending = 1'b0;
        next_port.tx_shift     = read_value(port.address, next_port.latched);
        if (port.address == ADDR_LATCHED) begin
          next_port.latched = events;
        end
      end
      if (byte_done) begin
        unique case (port.phase)
          st_command: begin
            next_port.address = rx_byte[6:0];
            if (rx_byte[READ_FLAG_BIT]) begin
              next_port.phase        = st_read;
              next_port.load_pending = 1'b1;
            end else begin
              next_port.phase = st_write;
            end
          end
          st_write: begin
            if (port.address == ADDR_LATCHED) begin
              next_port.latched = (port.latched & ~rx_byte) | events;
            end
            next_port.address = port.address + 1'b1;
          end
          st_read: begin
            next_port.address      = port.address + 1'b1;
            next_port.load_pending = 1'b1;
          end
          st_idle: begin
            next_port.phase = st_idle;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      port           <= '0;
      port.clk_sync  <= 3'h0;
      port.en_sync   <= 2'h3;
      port.phase     <= st_idle;
      port.bit_count <= BIT_COUNT_RESET;
      port.address   <= ADDR_RESET;
      port.latched   <= BYTE_RESET;
    end else begin
      port <= next_port;
    end
  end

  // ==========================================================================
  // Write stream buffer; overruns flag in the latched status instead
  byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_write_fifo (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_data),
    .o_out_valid (o_write_valid),
    .i_out_ready (i_write_ready),
    .o_out_data  (pop_data)
  );

  assign o_write_addr = pop_data[FIFO_WIDTH-1:BYTE_BITS];
  assign o_write_data = pop_data[BYTE_BITS-1:0];
  assign o_read_addr  = port.address;

  // ==========================================================================
  // Pins: both open-drain lines only ever pull low
  assign o_port_serial_out    = 1'b0;
  assign o_port_serial_out_oe = port.out_oe;
  assign o_service_request_n  = 1'b0;
  assign o_service_request_oe = |port.latched;

endmodule
